// ===== hw/ptme_params.svh
`ifndef PTME_PARAMS_SVH
`define PTME_PARAMS_SVH

// register byte offsets
`define PTME_OFF_CTRL0 8'h00
`define PTME_OFF_CTRL1 8'h04
`define PTME_OFF_CMPA 8'h08
`define PTME_OFF_CMPP 8'h0C
`define PTME_OFF_STATUS 8'h10
`define PTME_OFF_COUNT 8'h14

// control word 0 fields
`define PTME_C0_ON_BIT 0
`define PTME_C0_PAUSE_BIT 1

// control word 1 fields
`define PTME_C1_MODE_HI 7
`define PTME_C1_MODE_LO 6
`define PTME_C1_PF_HI 5
`define PTME_C1_PF_LO 4
`define PTME_C1_OLC_BIT 3
`define PTME_C1_INV_BIT 2
`define PTME_C1_CSRC_BIT 1
`define PTME_C1_CLR_BIT 0

// status fields, write one to clear
`define PTME_ST_A_BIT 0
`define PTME_ST_P_BIT 1

// reset values and counter limits
`define PTME_RST_CTRL1 8'h00
`define PTME_RST_CMP 10'h000
`define PTME_CNT_MAX 10'h3FF

// pin-function encodings
`define PTME_PF_NONE 2'b00
`define PTME_PF_LOW 2'b01
`define PTME_PF_HIGH 2'b10
`define PTME_PF_TGL 2'b11

`endif

// ===== hw/ptme_pkg.sv
package ptme_pkg;

  typedef enum logic [1:0] {
    PTME_MODE_CMP = 2'b00,
    PTME_MODE_CAP = 2'b01,
    PTME_MODE_PWM = 2'b10,
    PTME_MODE_TMR = 2'b11
  } ptme_mode_e;

  typedef struct packed {
    ptme_mode_e mode;
    logic [1:0] pin_function;
    logic output_level_ctrl;
    logic output_invert;
    logic capture_source_sel;
    logic clear_source_sel;
  } ptme_ctrl_s;

  typedef struct packed {
    logic counter_on;
    logic pause;
  } ptme_run_s;

endpackage : ptme_pkg

// ===== hw/ptme_top.sv
// Notes on behaviour
// - mode field 00 selects compare-match output mode.
// - clear-select low: clear on P match or overflow if P zero; A and P flags.
// - clear-select high: clear on A match; only the A flag is raised.
// - A zero: counter runs to 3FF and wraps, no A flag.
// - compare pin changes only on A match: high, low or toggle per field.
// - compare pin takes the output-level bit when counter-on rises.
// - mode 11 counts and flags as compare mode, pin not driven.
// - PWM period is P (1024 when zero); duty lasts A counts.
// - PWM output active whole period when A reaches or passes period.
// - PWM raises A flag on A match and P flag on P match.
// - PWM: level bit picks polarity, pin function forces or enables, invert flips.
// - clear-select is ignored in PWM mode.
// - counter-on rise starts pulse; external clock pin edge sets counter-on.
// - pulse ends on software clear or A match auto-clear with flag.
// - single pulse: counter zeroed only on counter-on rise; P, clear-select ignored.
// - mode 01 captures from capture pin or ext clock pin per select.
// - active edge copies counter into A and raises flag; counting continues.
// - capture mode: P match zeroes counter and raises flag.
// - capture mode pin function 11: no capture, counter keeps running.
// - counter-on rise zeroes counter; fall stops counter keeping its value.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ptme_params.svh"

module ptme_top #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_tick,
  input wire logic ext_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_output_pin,
  output logic timer_output_en,
  output logic match_a_flag,
  output logic match_p_flag
);

  // pin synchronisers: index 0 capture pin, 1 ext clock pin
  logic [1:0] pin_raw;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] sync3_r;

  ptme_pkg::ptme_ctrl_s ctrl_r;
  ptme_pkg::ptme_run_s run_r;
  logic on_d_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cmpa_r;
  logic [CNT_W-1:0] cmpp_r;
  logic flag_a_r;
  logic flag_p_r;
  logic cmp_lvl_r;
  logic pin_r;
  logic pin_en_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  logic wr_en;
  logic rd_phase;
  logic [CNT_W:0] inc;
  logic run;
  logic on_rise;
  logic a_hit;
  logic p_hit;
  logic single;
  logic cap_sig;
  logic cap_prev;
  logic cap_evt;
  logic ext_rise;
  logic clr_a;
  logic clr_p;
  logic set_a;
  logic set_p;
  logic pwm_act;
  logic pin_nxt;
  logic [31:0] rd_nxt;
  logic rd_ok;

  // compare match on the incremented count; zero reference means overflow when zero_is_wrap is set, else no match
  function automatic logic ref_hit(
    input logic [CNT_W:0] v,
    input logic [CNT_W-1:0] r,
    input logic zero_is_wrap
  );
    logic h;
    h = 1'b0;
    if (r == '0) begin
      h = zero_is_wrap & v[CNT_W];
    end else begin
      h = (v[CNT_W-1:0] == r) & ~v[CNT_W];
    end
    return h;
  endfunction : ref_hit

  function automatic logic is_reg(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = 1'b0;
    case (a)
      `PTME_OFF_CTRL0, `PTME_OFF_CTRL1, `PTME_OFF_CMPA,
      `PTME_OFF_CMPP, `PTME_OFF_STATUS, `PTME_OFF_COUNT: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : is_reg

  assign pin_raw = {ext_clock_pin, capture_input_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
        end
      end
    end
  endgenerate

  // apb decode
  assign rd_phase = psel & penable & ~pready_r;
  assign wr_en = psel & penable & pready_r & pwrite & is_reg(paddr);

  // timer events
  assign single = (ctrl_r.mode == ptme_pkg::PTME_MODE_PWM) &
                  (ctrl_r.pin_function == `PTME_PF_TGL);
  assign run = run_r.counter_on & ~run_r.pause & timer_tick & ~on_rise;
  assign on_rise = run_r.counter_on & ~on_d_r;
  assign inc = {1'b0, cnt_r} + {{CNT_W{1'b0}}, 1'b1};
  assign a_hit = run & ref_hit(inc, cmpa_r, 1'b0);
  assign p_hit = run & ref_hit(inc, cmpp_r, 1'b1);

  assign cap_sig = ctrl_r.capture_source_sel ? sync2_r[1] : sync2_r[0];
  assign cap_prev = ctrl_r.capture_source_sel ? sync3_r[1] : sync3_r[0];
  assign ext_rise = sync2_r[1] & ~sync3_r[1];

  always_comb begin
    cap_evt = 1'b0;
    if ((ctrl_r.mode == ptme_pkg::PTME_MODE_CAP) && run_r.counter_on) begin
      case (ctrl_r.pin_function)
        2'b00: cap_evt = cap_sig & ~cap_prev;
        2'b01: cap_evt = ~cap_sig & cap_prev;
        2'b10: cap_evt = cap_sig ^ cap_prev;
        default: cap_evt = 1'b0;
      endcase
    end
  end

  // flag sources per mode
  always_comb begin
    set_a = 1'b0;
    set_p = 1'b0;
    case (ctrl_r.mode)
      ptme_pkg::PTME_MODE_CMP, ptme_pkg::PTME_MODE_TMR: begin
        set_a = a_hit;
        set_p = p_hit & ~ctrl_r.clear_source_sel;
      end
      ptme_pkg::PTME_MODE_PWM: begin
        set_a = a_hit;
        set_p = p_hit & ~single;
      end
      ptme_pkg::PTME_MODE_CAP: begin
        set_a = cap_evt;
        set_p = p_hit;
      end
      default: begin
        set_a = 1'b0;
        set_p = 1'b0;
      end
    endcase
  end

  // counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (on_rise) begin
      cnt_r <= '0;
    end else if (run) begin
      case (ctrl_r.mode)
        ptme_pkg::PTME_MODE_CMP, ptme_pkg::PTME_MODE_TMR: begin
          if (ctrl_r.clear_source_sel ? a_hit : p_hit) begin
            cnt_r <= '0;
          end else begin
            cnt_r <= inc[CNT_W-1:0];
          end
        end
        ptme_pkg::PTME_MODE_PWM: begin
          if (p_hit && !single) begin
            cnt_r <= '0;
          end else begin
            cnt_r <= inc[CNT_W-1:0];
          end
        end
        ptme_pkg::PTME_MODE_CAP: begin
          if (p_hit) begin
            cnt_r <= '0;
          end else begin
            cnt_r <= inc[CNT_W-1:0];
          end
        end
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // counter-on and pause controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= '0;
    end else if (wr_en && paddr == `PTME_OFF_CTRL0) begin
      run_r.counter_on <= pwdata[`PTME_C0_ON_BIT];
      run_r.pause <= pwdata[`PTME_C0_PAUSE_BIT];
    end else if (single && a_hit) begin
      run_r.counter_on <= 1'b0;
    end else if (single && ext_rise) begin
      run_r.counter_on <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_d_r <= 1'b0;
    end else begin
      on_d_r <= run_r.counter_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ptme_pkg::ptme_ctrl_s'(`PTME_RST_CTRL1);
    end else if (wr_en && paddr == `PTME_OFF_CTRL1) begin
      ctrl_r <= ptme_pkg::ptme_ctrl_s'(pwdata[7:0]);
    end
  end

  // compare A: capture wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_r <= `PTME_RST_CMP;
    end else if (cap_evt) begin
      cmpa_r <= cnt_r;
    end else if (wr_en && paddr == `PTME_OFF_CMPA) begin
      cmpa_r <= pwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpp_r <= `PTME_RST_CMP;
    end else if (wr_en && paddr == `PTME_OFF_CMPP) begin
      cmpp_r <= pwdata[CNT_W-1:0];
    end
  end

  // sticky flags, set wins over clear
  assign clr_a = wr_en & (paddr == `PTME_OFF_STATUS) & pwdata[`PTME_ST_A_BIT];
  assign clr_p = wr_en & (paddr == `PTME_OFF_STATUS) & pwdata[`PTME_ST_P_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else begin
      flag_a_r <= set_a | (flag_a_r & ~clr_a);
      flag_p_r <= set_p | (flag_p_r & ~clr_p);
    end
  end

  // compare-mode pin level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_lvl_r <= 1'b0;
    end else if (ctrl_r.mode == ptme_pkg::PTME_MODE_CMP) begin
      if (on_rise) begin
        cmp_lvl_r <= ctrl_r.output_level_ctrl;
      end else if (a_hit) begin
        case (ctrl_r.pin_function)
          `PTME_PF_LOW: cmp_lvl_r <= 1'b0;
          `PTME_PF_HIGH: cmp_lvl_r <= 1'b1;
          `PTME_PF_TGL: cmp_lvl_r <= ~cmp_lvl_r;
          default: cmp_lvl_r <= cmp_lvl_r;
        endcase
      end
    end
  end

  // pwm and single-pulse active state
  always_comb begin
    case (ctrl_r.pin_function)
      `PTME_PF_NONE: pwm_act = 1'b0;
      `PTME_PF_LOW: pwm_act = 1'b1;
      `PTME_PF_HIGH: pwm_act = (cnt_r < cmpa_r);
      default: pwm_act = run_r.counter_on;
    endcase
  end

  always_comb begin
    pin_nxt = pin_r;
    case (ctrl_r.mode)
      ptme_pkg::PTME_MODE_CMP: pin_nxt = cmp_lvl_r ^ ctrl_r.output_invert;
      ptme_pkg::PTME_MODE_PWM: begin
        pin_nxt = (pwm_act ? ctrl_r.output_level_ctrl
                  : ~ctrl_r.output_level_ctrl) ^ ctrl_r.output_invert;
      end
      default: pin_nxt = pin_r;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 1'b0;
      pin_en_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
      pin_en_r <= (ctrl_r.mode == ptme_pkg::PTME_MODE_CMP) |
                  (ctrl_r.mode == ptme_pkg::PTME_MODE_PWM);
    end
  end

  // register read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_ok = is_reg(paddr);
    case (paddr)
      `PTME_OFF_CTRL0: begin
        rd_nxt[`PTME_C0_ON_BIT] = run_r.counter_on;
        rd_nxt[`PTME_C0_PAUSE_BIT] = run_r.pause;
      end
      `PTME_OFF_CTRL1: rd_nxt[7:0] = ctrl_r;
      `PTME_OFF_CMPA: rd_nxt[CNT_W-1:0] = cmpa_r;
      `PTME_OFF_CMPP: rd_nxt[CNT_W-1:0] = cmpp_r;
      `PTME_OFF_STATUS: begin
        rd_nxt[`PTME_ST_A_BIT] = flag_a_r;
        rd_nxt[`PTME_ST_P_BIT] = flag_p_r;
      end
      `PTME_OFF_COUNT: rd_nxt[CNT_W-1:0] = cnt_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= rd_phase;
      pslverr_r <= rd_phase & ~rd_ok;
      if (rd_phase && !pwrite) begin
        prdata_r <= rd_nxt;
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign timer_output_pin = pin_r;
  assign timer_output_en = pin_en_r;
  assign match_a_flag = flag_a_r;
  assign match_p_flag = flag_p_r;

endmodule : ptme_top
`default_nettype wire

// ===== dv/ptme_pin_src.sv
`timescale 1ns/100ps
`default_nettype none
// square wave source for capture, high-time meter as the pin's load
module ptme_pin_src (
  input wire logic pclk,
  input wire logic run,
  input wire logic [7:0] half,
  input wire logic win,
  input wire logic load_pin,
  output logic src_pin,
  output logic [15:0] high_cycles
);
  logic [7:0] cnt_q = 8'h00;
  logic src_q = 1'b0;
  logic win_q = 1'b0;
  logic [15:0] hi_q = 16'h0000;
  assign src_pin = src_q;
  assign high_cycles = hi_q;
  always @(posedge pclk) begin
    win_q <= win;
    if (win && !win_q) hi_q <= {15'h0000, load_pin};
    else if (win && load_pin) hi_q <= hi_q + 16'h0001;
    if (!run) cnt_q <= 8'h00;
    else if (cnt_q == half - 8'h01) begin
      cnt_q <= 8'h00;
      src_q <= ~src_q;
    end else cnt_q <= cnt_q + 8'h01;
  end
endmodule : ptme_pin_src
`default_nettype wire

// ===== dv/ptme_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ptme_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic timer_output_pin,
  input wire logic timer_output_en,
  input wire logic match_a_flag,
  input wire logic match_p_flag
);
  logic wr;
  logic [7:0] c1_q;
  logic on_q;
  logic az_q;
  logic [1:0] age_q;
  assign wr = psel && penable && pready && pwrite;
  // shadow of control writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= 8'h00;
      on_q <= 1'b0;
      az_q <= 1'b1;
      age_q <= 2'd0;
    end else begin
      if (wr && paddr == 8'h04) begin
        c1_q <= pwdata[7:0];
        age_q <= 2'd0;
      end else if (age_q != 2'd3) age_q <= age_q + 2'd1;
      if (wr && paddr == 8'h00) on_q <= pwdata[0];
      if (wr && paddr == 8'h08) az_q <= pwdata[9:0] == 10'h000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  flag_a_hold_a: assert property (match_a_flag && !(wr && paddr == 8'h10
    && pwdata[0]) |=> match_a_flag) else $error("a flag dropped");
  flag_p_hold_a: assert property (match_p_flag && !(wr && paddr == 8'h10
    && pwdata[1]) |=> match_p_flag) else $error("p flag dropped");
  pin_en_a: assert property (wr && paddr == 8'h04 |=> ##1
    timer_output_en == !$past(pwdata[6], 2)) else $error("pin enable");
  p_quiet_a: assert property (c1_q[7] == c1_q[6] && c1_q[0]
    |=> !$rose(match_p_flag)) else $error("p flag with a clear");
  a_zero_a: assert property (az_q && c1_q[7:6] != 2'b01
    |=> !$rose(match_a_flag)) else $error("a flag with a zero");
  cap_off_a: assert property (c1_q[7:4] == 4'b0111 && age_q == 2'd3
    |=> !$rose(match_a_flag)) else $error("capture while off");
  init_lvl_a: assert property (wr && paddr == 8'h00 && pwdata[0] && !on_q
    && c1_q[7:6] == 2'b00 |-> ##[2:3]
    timer_output_pin == (c1_q[3] ^ c1_q[2])) else $error("initial level");
  pwm_force_a: assert property (c1_q[7:5] == 3'b100 && age_q == 2'd3
    |-> timer_output_pin == (c1_q[4] ~^ c1_q[3]) ^ c1_q[2])
    else $error("forced level");
  pwm_c: cover property (c1_q[7:4] == 4'b1010 && $rose(match_a_flag));
  cap_c: cover property (c1_q[7:6] == 2'b01 && $rose(match_a_flag));
  wrap_c: cover property (c1_q[7:6] == 2'b11 && $rose(match_p_flag));
endmodule : ptme_chk
bind ptme_top ptme_chk #(.ADDR_W(ADDR_W)) u_ptme_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .timer_output_pin(timer_output_pin), .timer_output_en(timer_output_en),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
`default_nettype wire

// ===== dv/tb_periodic_timer_mode_engine.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module tb_periodic_timer_mode_engine;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic ext_pin = 1'b0;
  logic run = 1'b0;
  logic win = 1'b0;
  logic tick = 1'b1;
  logic [31:0] prdata, q, q1;
  logic pready, pslverr, pin, pin_en, fa, fp, src, err;
  logic [15:0] hi;
  int n_mismatch = 0;
  int n_compared = 0;
  int a, p;
  always #12.5 pclk = ~pclk;
  ptme_top u_ptme_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(tick), .ext_clock_pin(ext_pin), .capture_input_pin(src),
    .timer_output_pin(pin), .timer_output_en(pin_en),
    .match_a_flag(fa), .match_p_flag(fp));
  ptme_pin_src u_ptme_pin_src (.pclk(pclk), .run(run), .half(8'h25),
    .win(win), .load_pin(pin), .src_pin(src), .high_cycles(hi));
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                    input string nm);
    bus(1'b0, ad, 32'h0000_0000);
    `CHK(nm, e, q)
  endtask : rd
  task automatic pulse_ext();
    ext_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    ext_pin <= 1'b0;
  endtask : pulse_ext
  function automatic int pwm_high(int a, int p, int k, logic inv);
    int per;
    int h;
    per = (p == 0) ? 1024 : p;
    h = ((a >= per) ? per : a) * k;
    return inv ? per * k - h : h;
  endfunction : pwm_high
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    #500_000;
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(32'hc4c8));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i < 5; i++) rd(8'(4 * i), 32'h0000_0000, "reset value");
    rd(8'h40, 32'h0000_0000, "unmapped");
    `CHK("slverr", 1'b1, err)
    for (int i = 0; i < 4; i++) begin
      a = 4 + $urandom_range(4);
      p = i[0] ? 2 : a + 5 + $urandom_range(10);
      wr(8'h00, 32'h0000_0000);
      wr(8'h04, {24'h00_0000, i[1], i[1], 4'b1000, 1'b0, i[0]});
      wr(8'h08, 32'(a));
      wr(8'h0C, 32'(p));
      wr(8'h10, 32'h0000_0003);
      wr(8'h00, 32'h0000_0001);
      repeat (100) @(posedge pclk);
      rd(8'h10, i[0] ? 1 : 3, "cmp flags");
      `CHK("pin en", !i[1], pin_en)
      if (!i[1]) `CHK("match pin", 1'b1, pin)
      `CHK("a flag pin", 1'b1, fa)
      `CHK("p flag pin", !i[0], fp)
    end
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_00C0);
    wr(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0000);
    wr(8'h10, 32'h0000_0003);
    wr(8'h00, 32'h0000_0001);
    repeat (1100) @(posedge pclk);
    rd(8'h10, 32'h0000_0002, "wrap flags");
    wr(8'h00, 32'h0000_0000);
    bus(1'b0, 8'h14, 32'h0000_0000);
    q1 = q;
    repeat (10) @(posedge pclk);
    rd(8'h14, q1, "held count");
    wr(8'h00, 32'h0000_0001);
    bus(1'b0, 8'h14, 32'h0000_0000);
    `CHK("restart", 1'b1, q < 8)
    wr(8'h00, 32'h0000_0003);
    bus(1'b0, 8'h14, 32'h0000_0000);
    q1 = q;
    tick <= 1'b0;
    wr(8'h00, 32'h0000_0001);
    repeat (5) @(posedge pclk);
    rd(8'h14, q1, "paused count");
    tick <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      p = (i == 3) ? 0 : 10 + $urandom_range(30);
      a = (i == 1) ? p : (i == 2) ? p + 7 : 3 + $urandom_range(6);
      wr(8'h00, 32'h0000_0000);
      wr(8'h04, {24'h00_0000, 4'b1010, 1'b1, i[0], 1'b0,
        1'($urandom_range(1))});
      wr(8'h08, 32'(a));
      wr(8'h0C, 32'(p));
      wr(8'h10, 32'h0000_0003);
      wr(8'h00, 32'h0000_0001);
      repeat (8) @(posedge pclk);
      win <= 1'b1;
      repeat (4 * ((p == 0) ? 1024 : p)) @(posedge pclk);
      win <= 1'b0;
      @(posedge pclk);
      `CHK("duty", 16'(pwm_high(a, p, 4, i[0])), hi)
      if (i == 0) rd(8'h10, 32'h0000_0003, "pwm flags");
    end
    wr(8'h04, 32'h0000_0098);
    repeat (4) @(posedge pclk);
    `CHK("forced", 1'b1, pin)
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_00B8);
    a = 20 + $urandom_range(20);
    wr(8'h08, 32'(a));
    wr(8'h10, 32'h0000_0003);
    win <= 1'b1;
    pulse_ext();
    repeat (80) @(posedge pclk);
    win <= 1'b0;
    rd(8'h00, 32'h0000_0000, "on cleared");
    rd(8'h10, 32'h0000_0001, "pulse flag");
    `CHK("width", 1'b1, hi >= a && hi <= a + 2)
    wr(8'h04, 32'h0000_0040);
    wr(8'h0C, 32'h0000_0032);
    wr(8'h10, 32'h0000_0003);
    run <= 1'b1;
    wr(8'h00, 32'h0000_0001);
    repeat (300) @(posedge pclk);
    rd(8'h10, 32'h0000_0003, "cap flags");
    bus(1'b0, 8'h08, 32'h0000_0000);
    `CHK("bounded", 1'b1, q < 50)
    run <= 1'b0;
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0070);
    wr(8'h10, 32'h0000_0003);
    run <= 1'b1;
    wr(8'h00, 32'h0000_0001);
    repeat (300) @(posedge pclk);
    rd(8'h10, 32'h0000_0002, "no capture");
    run <= 1'b0;
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0042);
    wr(8'h10, 32'h0000_0003);
    wr(8'h00, 32'h0000_0001);
    pulse_ext();
    repeat (10) @(posedge pclk);
    rd(8'h10, 32'h0000_0001, "ext capture");
    close_out();
  end
endmodule : tb_periodic_timer_mode_engine
`default_nettype wire
